/* File: nand_dev_model.sv */
`timescale 1ns/1ps
module nand_dev_model
  import nand_feat_pkg::*;
#(
  parameter int PAGE_READ_NS  = 2000,
  parameter int FEAT_BUSY_NS  = 1000,
  parameter int IFC_CHANGE_NS = 3000,
  parameter int IFC_BIT       = 4
)(
  input  wire logic       i_pwr_rst,
  input  wire logic       i_bad_uid,
  input  wire logic       i_ce_n,
  input  wire logic       i_cle,
  input  wire logic       i_ale,
  input  wire logic       i_we_n,
  input  wire logic       i_re_n,
  input  wire logic [7:0] i_dq,
  output logic [7:0]      o_dq,
  output logic            o_rb_n,
  output logic            o_viol
);
  logic [7:0] feat [4][4];
  logic [7:0] pbuf [4];
  logic [7:0] cmd;
  logic [7:0] fa;
  logic [8:0] col;
  logic [8:0] ncol;
  logic       stat;
  logic       rsel;
  logic       ifc;
  int         np;
  int         nad;
  int         idx;
  realtime    busy_end;
  realtime    t_addr;

  function automatic int fidx(logic [7:0] a);
    case (a)
      FA_TIMING_MODE: return 0;
      FA_DRIVE:       return 1;
      FA_RB_PULLDOWN: return 2;
      FA_ARRAY_OP:    return 3;
      default:        return -1;
    endcase
  endfunction

  function automatic logic [7:0] uid_byte(logic [8:0] i);
    logic [7:0] b;
    b = 8'h5A ^ (8'(i[3:0]) * 8'h1D);
    // Damage only copy 0 so a good later copy exists
    if (i_bad_uid && i == 9'h003) b = b ^ 8'h01;
    return i[4] ? ~b : b;
  endfunction

  task automatic go_busy(int ns);
    o_rb_n = 1'b0;
    busy_end = $realtime + ns;
  endtask

  always #10 if (!o_rb_n && $realtime >= busy_end) o_rb_n = 1'b1;

  always @(posedge i_pwr_rst) begin
    foreach (feat[i, j]) feat[i][j] = 8'h00;
    o_rb_n = 1'b1;
    o_dq = 8'hA5;
    o_viol = 1'b0;
    stat = 1'b0;
    rsel = 1'b0;
    cmd = 8'h00;
  end

  always @(posedge i_we_n) begin
    if (!i_ce_n && i_cle) begin
      if (i_dq == CMD_STATUS) stat = 1'b1;
      else if (i_dq == CMD_READ_MODE) stat = 1'b0;
      else if (i_dq == CMD_RAND_READ) begin
        rsel = 1'b1;
        nad = 0;
      end else if (i_dq == CMD_RAND_CONF) begin
        col = ncol;
        rsel = 1'b0;
      end else if (o_rb_n || !(i_dq inside {CMD_UID_READ, CMD_SET_FEAT})) begin
        cmd = i_dq;
        np = 0;
        stat = 1'b0;
      end
    end else if (!i_ce_n && i_ale) begin
      if (rsel) begin
        ncol = (nad != 0) ? {i_dq[0], ncol[7:0]} : {1'b0, i_dq};
        nad++;
      end else begin
        fa = i_dq;
        col = 9'h000;
        t_addr = $realtime;
        if (cmd == CMD_UID_READ && i_dq != ADDR_ZERO) o_viol = 1'b1;
        if (cmd == CMD_UID_READ) go_busy(PAGE_READ_NS);
        if (cmd == CMD_GET_FEAT) go_busy(FEAT_BUSY_NS);
      end
    end else if (!i_ce_n && cmd == CMD_SET_FEAT && np < PARAM_BYTES) begin
      if (np == 0 && $realtime - t_addr < T_ADL_NS) o_viol = 1'b1;
      pbuf[np] = i_dq;
      np++;
      if (np == PARAM_BYTES) begin
        idx = fidx(fa);
        ifc = (idx == 0) && (pbuf[0][IFC_BIT] != feat[0][0][IFC_BIT]);
        // Reserved addresses keep nothing
        if (idx >= 0) foreach (pbuf[k]) feat[idx][k] = pbuf[k];
        go_busy(ifc ? IFC_CHANGE_NS : FEAT_BUSY_NS);
      end
    end
  end

  always @(negedge i_re_n) begin
    if (!i_ce_n && stat) o_dq = o_rb_n ? STATUS_RDY_BIT : 8'h00;
    else if (!i_ce_n && cmd == CMD_UID_READ) o_dq = uid_byte(col);
    else if (!i_ce_n && cmd == CMD_GET_FEAT)
      o_dq = (fidx(fa) >= 0 && col < 9'd4) ? feat[fidx(fa)][col[1:0]] : 8'h00;
  end

  // Released bus shows the inverse so stale data cannot pass
  always @(posedge i_re_n) begin
    o_dq = ~o_dq;
    if (!stat) col = col + 9'd1;
  end
endmodule

/* File: nand_feat_host.sv */
`timescale 1ns/1ps
module nand_feat_host
  import nand_feat_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_rb_n,
  input  wire logic [7:0]  i_dq,
  output logic [7:0]       o_dq,
  output logic             o_dq_oe_n,
  output logic             o_ce_n,
  output logic             o_cle,
  output logic             o_ale,
  output logic             o_we_n,
  output logic             o_re_n
);
  import nand_feat_pkg::*;

  logic [1:0] rb_sync_reg;
  logic [7:0] dq_s1_reg, dq_s2_reg;
  seq_state_t  st_reg, st_next;
  logic [1:0]  op_reg, op_next;
  logic        poll_reg, poll_next, busy_reg, busy_next;
  logic        ok_reg, ok_next, rsv_reg, rsv_next;
  logic [7:0]  fa_reg, fa_next, col_reg, col_next, idx_reg, idx_next;
  logic [31:0] pw_reg, pw_next, pr_reg, pr_next, uid_reg, uid_next;
  logic [7:0]  xor_fail_reg, xor_fail_next;
  logic [7:0]  wait_reg, wait_next;
  logic        cyc_start, cyc_done;
  logic [1:0]  cyc_kind;
  logic [7:0]  cyc_wdata, cyc_rdata;
  logic [7:0]  mem [0:UID_COPY_BYTES-1];
  logic [31:0] rd_next;
  logic        rdy_next;

  function automatic logic feat_defined(input logic [7:0] fa);
    feat_defined = (fa == FA_TIMING_MODE) || (fa == FA_DRIVE) ||
                   (fa == FA_RB_PULLDOWN) || (fa == FA_ARRAY_OP);
  endfunction

  nand_pin_cycle u_cyc (
    .i_core_clk (i_core_clk), .i_sys_rst (i_sys_rst), .i_ce (i_clk_en),
    .i_start (cyc_start), .i_kind (cyc_kind), .i_wdata (cyc_wdata),
    .i_dq_sync (dq_s2_reg), .o_done (cyc_done), .o_rdata (cyc_rdata),
    .o_cle (o_cle), .o_ale (o_ale), .o_we_n (o_we_n), .o_re_n (o_re_n),
    .o_dq (o_dq), .o_dq_oe_n (o_dq_oe_n)
  );

  // Writes land only at the edge where the master sees pready high
  wire bus_wr = psel && penable && pwrite && pready;
  wire go = bus_wr && (paddr == REG_CTRL) && pwdata[CTRL_GO_BIT] && !busy_reg;
  wire [7:0] n_bytes = (op_reg == OP_UID_READ) ? 8'(UID_COPY_BYTES) : 8'(PARAM_BYTES);
  wire [7:0] p_byte = pw_reg[8*idx_reg[1:0] +: 8];

  always_comb begin
    st_next = st_reg; op_next = op_reg; poll_next = poll_reg; busy_next = busy_reg;
    ok_next = ok_reg; rsv_next = rsv_reg; fa_next = fa_reg; col_next = col_reg;
    idx_next = idx_reg; pw_next = pw_reg; pr_next = pr_reg; uid_next = uid_reg;
    xor_fail_next = xor_fail_reg; wait_next = wait_reg;
    cyc_start = 1'b0; cyc_kind = 2'd0; cyc_wdata = 8'h00;
    if (bus_wr && paddr == REG_FEAT_ADDR && !busy_reg) fa_next = pwdata[7:0];
    if (bus_wr && paddr == REG_PARAM_WR && !busy_reg) pw_next = pwdata;
    if (bus_wr && paddr == REG_COL && !busy_reg) col_next = pwdata[7:0];
    unique case (st_reg)
      S_IDLE: if (go) begin
        op_next = pwdata[CTRL_OP_LSB +: 2];
        poll_next = pwdata[CTRL_USE_POLL];
        busy_next = 1'b1;
        rsv_next = !feat_defined(fa_reg) && pwdata[CTRL_OP_LSB +: 2] != OP_UID_READ;
        idx_next = 8'h00;
        xor_fail_next = 8'h00;
        st_next = S_PWR;
      end
      S_PWR: if (rb_sync_reg[1]) begin
        // Only start once all dies report ready on R/B#
        cyc_start = 1'b1;
        cyc_kind = 2'd0;
        cyc_wdata = (op_reg == OP_UID_READ) ? CMD_UID_READ :
                    (op_reg == OP_SET_FEAT) ? CMD_SET_FEAT : CMD_GET_FEAT;
        st_next = S_CMD;
      end
      S_CMD: if (cyc_done) begin
        cyc_start = 1'b1;
        cyc_kind = 2'd1;
        cyc_wdata = (op_reg == OP_UID_READ) ? ADDR_ZERO : fa_reg;
        st_next = S_ADDR;
      end
      S_ADDR: if (cyc_done) begin
        wait_next = (op_reg == OP_SET_FEAT) ? 8'(ADL_CYC) : 8'(WB_CYC);
        st_next = (op_reg == OP_SET_FEAT) ? S_ADL : S_BUSY;
      end
      S_ADL: if (wait_reg != 8'h00) begin
        wait_next = wait_reg - 8'h01;
      end else if (idx_reg == 8'h00 || cyc_done) begin
        // Leave only after the last byte's strobe has fully finished
        if (idx_reg == 8'(PARAM_BYTES)) begin
          wait_next = 8'(WB_CYC);
          st_next = S_BUSY;
        end else begin
          cyc_start = 1'b1;
          cyc_kind = 2'd2;
          cyc_wdata = p_byte;
          idx_next = idx_reg + 8'h01;
        end
      end
      S_BUSY: if (wait_reg != 8'h00) begin
        wait_next = wait_reg - 8'h01;
      end else if (poll_reg) begin
        cyc_start = 1'b1;
        cyc_kind = 2'd0;
        cyc_wdata = CMD_STATUS;
        idx_next = 8'h00;
        st_next = S_POLL;
      end else if (rb_sync_reg[1]) begin
        // Busy covers page read, feature or interface change time alike
        st_next = (op_reg == OP_SET_FEAT) ? S_DONE : S_RDMODE;
      end
      S_POLL: if (cyc_done) begin
        // First done is the 70h command itself; only read results count
        if (idx_reg != 8'h00 && (cyc_rdata & STATUS_RDY_BIT) != 8'h00) begin
          st_next = (op_reg == OP_SET_FEAT) ? S_DONE : S_RDMODE;
        end else begin
          cyc_start = 1'b1;
          cyc_kind = 2'd3;
          idx_next = 8'h01;
        end
      end
      S_RDMODE: begin
        // Sent after R/B# waits too; harmless and keeps one path
        cyc_start = 1'b1;
        cyc_kind = 2'd0;
        cyc_wdata = CMD_READ_MODE;
        idx_next = 8'h00;
        st_next = S_RCOL;
      end
      S_RCOL: if (cyc_done) begin
        // Steps: 05h, column, column high, E0h
        if (op_reg == OP_UID_READ && col_reg != 8'h00 && idx_reg != 8'h04) begin
          cyc_start = 1'b1;
          cyc_kind = (idx_reg == 8'h01 || idx_reg == 8'h02) ? 2'd1 : 2'd0;
          cyc_wdata = (idx_reg == 8'h00) ? CMD_RAND_READ :
                      (idx_reg == 8'h01) ? col_reg :
                      (idx_reg == 8'h02) ? ADDR_ZERO : CMD_RAND_CONF;
          idx_next = idx_reg + 8'h01;
        end else begin
          idx_next = 8'h00;
          st_next = S_DOUT;
        end
      end
      S_DOUT: if (cyc_done || idx_reg == 8'h00) begin
        if (idx_reg == n_bytes) begin
          st_next = S_DONE;
        end else begin
          cyc_start = 1'b1;
          cyc_kind = 2'd3;
          idx_next = idx_reg + 8'h01;
        end
      end
      S_DONE: begin
        busy_next = 1'b0;
        ok_next = (op_reg != OP_UID_READ) || (xor_fail_reg == 8'h00);
        if (op_reg == OP_GET_FEAT && rsv_reg) pr_next = 32'h0000_0000;
        st_next = S_IDLE;
      end
      default: st_next = S_IDLE;
    endcase
  end

  always_comb begin
    rdy_next = psel && penable && !pready;
    unique case (paddr)
      REG_STATUS:    rd_next = {29'h0, rsv_reg, ok_reg, busy_reg};
      REG_FEAT_ADDR: rd_next = {24'h0, fa_reg};
      REG_PARAM_WR:  rd_next = pw_reg;
      REG_PARAM_RD:  rd_next = pr_reg;
      REG_UID_LO:    rd_next = uid_reg;
      REG_COL:       rd_next = {24'h0, col_reg};
      default:       rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rb_sync_reg <= 2'b00; dq_s1_reg <= 8'h00; dq_s2_reg <= 8'h00;
      st_reg <= S_IDLE; op_reg <= OP_GET_FEAT; poll_reg <= 1'b0; busy_reg <= 1'b0;
      ok_reg <= 1'b0; rsv_reg <= 1'b0; fa_reg <= 8'h00; col_reg <= 8'h00;
      idx_reg <= 8'h00; pw_reg <= 32'h0; pr_reg <= 32'h0; uid_reg <= 32'h0;
      xor_fail_reg <= 8'h00; wait_reg <= 8'h00;
      prdata <= 32'h0; pready <= 1'b0; pslverr <= 1'b0; o_ce_n <= 1'b1;
    end else if (i_clk_en) begin
      rb_sync_reg <= {rb_sync_reg[0], i_rb_n};
      dq_s1_reg <= i_dq;
      dq_s2_reg <= dq_s1_reg;
      st_reg <= st_next; op_reg <= op_next; poll_reg <= poll_next;
      busy_reg <= busy_next; ok_reg <= ok_next; rsv_reg <= rsv_next;
      fa_reg <= fa_next; col_reg <= col_next; idx_reg <= idx_next;
      pw_reg <= pw_next; uid_reg <= uid_next; wait_reg <= wait_next;
      pr_reg <= pr_next;
      xor_fail_reg <= xor_fail_next;
      if (st_reg == S_DOUT && cyc_done) begin
        mem[idx_reg[4:0] - 5'd1] <= cyc_rdata;
        if (op_reg != OP_UID_READ && !rsv_reg)
          pr_reg[8*2'(idx_reg[1:0] - 2'd1) +: 8] <= cyc_rdata;
        if (op_reg == OP_UID_READ && idx_reg > 8'(UID_HALF_BYTES) &&
            (cyc_rdata ^ mem[idx_reg[4:0] - 5'd17]) != ID_OK_BYTE)
          xor_fail_reg <= xor_fail_reg + 8'h01;
        if (op_reg == OP_UID_READ && idx_reg <= 8'd4)
          uid_reg[8*2'(idx_reg[1:0] - 2'd1) +: 8] <= cyc_rdata;
      end
      prdata <= rd_next;
      pready <= rdy_next;
      pslverr <= 1'b0;
      o_ce_n <= !busy_next;
    end
  end

  sequence read_mode_cmd_s;
    o_cle && !o_ale && o_dq == CMD_READ_MODE && !o_dq_oe_n;
  endsequence

  chk_busy_released: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (st_reg == S_DONE && i_clk_en) |=> !busy_reg)
    else $error("Busy not released after done");
  chk_set_four_bytes: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (st_reg == S_ADL) |-> idx_reg <= 8'(PARAM_BYTES))
    else $error("Too many parameter bytes");
  chk_read_mode_cmd: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (st_reg == S_RDMODE && i_clk_en) |=> read_mode_cmd_s)
    else $error("Read mode command not driven");
  chk_uid_addr_zero: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (st_reg == S_CMD && cyc_done && op_reg == OP_UID_READ && i_clk_en) |=>
      (o_ale && o_dq == ADDR_ZERO))
    else $error("Unique ID address cycle not zero");
  chk_pready_pulse: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (pready && i_clk_en) |=> !pready)
    else $error("Ready held longer than one cycle");
endmodule

/* File: nand_feat_host_tb.sv */
`timescale 1ns/1ps
module nand_feat_host_tb;
  import nand_feat_pkg::*;
  logic        i_core_clk;
  logic        i_sys_rst;
  logic        i_clk_en;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] q;
  logic [31:0] p;
  logic [7:0]  h_dq;
  logic [7:0]  d_dq;
  logic [7:0]  dq;
  logic [7:0]  fas [4] = '{FA_TIMING_MODE, FA_DRIVE, FA_RB_PULLDOWN, FA_ARRAY_OP};
  logic [7:0]  rsv [5] = '{8'h00, 8'h02, 8'h7F, 8'h82, 8'hFF};
  logic        oe_n, ce_n, cle, ale, we_n, re_n, rb_n, pwr_rst, bad_uid, viol, pe;
  int          n_errors;
  int          total_checks;
  int          seed;
  int          r;

  assign dq = oe_n ? d_dq : h_dq;

  nand_feat_host nand_feat_host_inst (.i_core_clk, .i_sys_rst, .i_clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .i_rb_n(rb_n), .i_dq(dq),
    .o_dq(h_dq), .o_dq_oe_n(oe_n), .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n),
    .o_re_n(re_n));
  nand_dev_model nand_dev_model_inst (.i_pwr_rst(pwr_rst), .i_bad_uid(bad_uid),
    .i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n), .i_dq(dq),
    .o_dq(d_dq), .o_rb_n(rb_n), .o_viol(viol));

  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    @(posedge i_core_clk);
    while (pready !== 1'b1) @(posedge i_core_clk);
    o = prdata;
    pe = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge i_core_clk);
  endtask

  // Start an operation and wait until the busy flag drops
  task run(input logic [1:0] op, input logic poll);
    int n;
    apb(1'b1, REG_CTRL, (32'(poll) << CTRL_USE_POLL) | (32'(op) << CTRL_OP_LSB) | 32'h1, rd);
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0, rd);
      n++;
    end while (rd[0] !== 1'b0 && n < 3000);
  endtask

  task fset(input logic [7:0] fa, input logic [31:0] d, input logic poll);
    apb(1'b1, REG_FEAT_ADDR, 32'(fa), rd);
    apb(1'b1, REG_PARAM_WR, d, rd);
    run(OP_SET_FEAT, poll);
  endtask

  task fget(input logic [7:0] fa, input logic poll, output logic [31:0] o);
    apb(1'b1, REG_FEAT_ADDR, 32'(fa), rd);
    run(OP_GET_FEAT, poll);
    apb(1'b0, REG_PARAM_RD, 32'h0, o);
  endtask

  task do_reset;
    i_sys_rst <= 1'b1;
    pwr_rst <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    pwr_rst <= 1'b0;
    @(posedge i_core_clk);
  endtask

  function automatic logic [7:0] exp_uid(int i);
    logic [7:0] b;
    b = 8'h5A ^ (8'(i % 16) * 8'h1D);
    return ((i / 16) % 2 == 1) ? ~b : b;
  endfunction

  function automatic logic [31:0] exp_uid4(int c);
    return {exp_uid(c + 3), exp_uid(c + 2), exp_uid(c + 1), exp_uid(c)};
  endfunction

  function automatic logic [7:0] legal_p1(logic [7:0] fa, int v);
    if (fa == FA_TIMING_MODE) return 8'(v % 6);
    if (fa == FA_ARRAY_OP) return (v % 3 == 2) ? ARRAY_OP_PROT : 8'(v % 3);
    return 8'(v % 4);
  endfunction

  initial begin
    #500000;
    n_errors++;
    report_and_stop;
  end

  initial begin
    seed = 87139;
    n_errors = 0;
    total_checks = 0;
    {i_sys_rst, i_clk_en, psel, penable, pwrite, paddr, pwdata} = '0;
    {pwr_rst, bad_uid} = 2'b00;
    #1 i_clk_en = 1'b1;
    do_reset;
    chk(32'({ce_n, we_n, re_n, oe_n, cle, ale}), 32'h3C);
    apb(1'b0, 8'h1C, 32'h0, rd);
    chk(32'(pe), 32'h0);
    foreach (fas[i]) begin
      fget(fas[i], 1'b0, q);
      chk(q, 32'h0);
    end
    for (int i = 0; i < 11; i++) begin
      r = $random(seed) & 255;
      p = {24'h0, (i < 8) ? legal_p1(fas[i % 4], r) : legal_p1(FA_ARRAY_OP, i)};
      fset((i < 8) ? fas[i % 4] : FA_ARRAY_OP, p, 1'(i / 4));
      chk(32'(rd[0]), 32'h0);
      fget((i < 8) ? fas[i % 4] : FA_ARRAY_OP, 1'(i % 2), q);
      chk(q, p);
      chk(32'(viol), 32'h0);
    end
    foreach (rsv[i]) begin
      r = $random(seed);
      fset(rsv[i], 32'(r), 1'b0);
      fget(rsv[i], 1'b0, q);
      chk(q, 32'h0);
      chk(32'(rd[2]), 32'h1);
    end
    apb(1'b1, REG_FEAT_ADDR, 32'(FA_DRIVE), rd);
    apb(1'b1, REG_PARAM_WR, 32'h2, rd);
    apb(1'b1, REG_CTRL, (32'(OP_SET_FEAT) << CTRL_OP_LSB) | 32'h1, rd);
    apb(1'b1, REG_FEAT_ADDR, 32'h0, rd);
    apb(1'b0, REG_FEAT_ADDR, 32'h0, q);
    chk(q, 32'(FA_DRIVE));
    // First start is refused while the set is busy; it only waits
    run(OP_GET_FEAT, 1'b0);
    run(OP_GET_FEAT, 1'b0);
    apb(1'b0, REG_PARAM_RD, 32'h0, q);
    chk(q, 32'h2);
    for (int i = 0; i < 4; i++) begin
      bad_uid <= 1'(i / 2);
      apb(1'b1, REG_COL, (i == 3) ? 32'd32 : 32'd0, rd);
      run(OP_UID_READ, 1'(i % 2));
      chk(32'(rd[1]), (i == 2) ? 32'h0 : 32'h1);
      apb(1'b0, REG_UID_LO, 32'h0, q);
      chk(q, exp_uid4((i == 3) ? 32 : 0) ^ ((i == 2) ? 32'h0100_0000 : 32'h0));
      chk(32'(viol), 32'h0);
    end
    fset(FA_ARRAY_OP, 32'(ARRAY_OP_OTP), 1'b0);
    do_reset;
    fget(FA_ARRAY_OP, 1'b1, q);
    chk(q, 32'h0);
    report_and_stop;
  end
endmodule

/* File: nand_feat_pkg.sv */
package nand_feat_pkg;
  localparam logic [7:0] CMD_READ_MODE   = 8'h00;
  localparam logic [7:0] CMD_RAND_READ   = 8'h05;
  localparam logic [7:0] CMD_RAND_CONF   = 8'hE0;
  localparam logic [7:0] CMD_STATUS      = 8'h70;
  localparam logic [7:0] CMD_UID_READ    = 8'hED;
  localparam logic [7:0] CMD_GET_FEAT    = 8'hEE;
  localparam logic [7:0] CMD_SET_FEAT    = 8'hEF;
  localparam logic [7:0] ADDR_ZERO       = 8'h00;
  localparam logic [7:0] FA_TIMING_MODE  = 8'h01;
  localparam logic [7:0] FA_DRIVE        = 8'h80;
  localparam logic [7:0] FA_RB_PULLDOWN  = 8'h81;
  localparam logic [7:0] FA_ARRAY_OP     = 8'h90;
  localparam logic [7:0] ARRAY_OP_NORMAL = 8'h00;
  localparam logic [7:0] ARRAY_OP_OTP    = 8'h01;
  localparam logic [7:0] ARRAY_OP_PROT   = 8'h03;
  localparam logic [7:0] STATUS_RDY_BIT  = 8'h40;
  localparam logic [7:0] ID_OK_BYTE      = 8'hFF;
  localparam int         UID_COPY_BYTES  = 32;
  localparam int         UID_HALF_BYTES  = 16;
  localparam int         UID_COPIES      = 16;
  localparam int         PARAM_BYTES     = 4;
  localparam int         PPAGE_BYTES     = 256;
  localparam int         PPAGE_CRC_OFS   = 254;
  // Register byte offsets on the APB side
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_STATUS      = 8'h04;
  localparam logic [7:0] REG_FEAT_ADDR   = 8'h08;
  localparam logic [7:0] REG_PARAM_WR    = 8'h0C;
  localparam logic [7:0] REG_PARAM_RD    = 8'h10;
  localparam logic [7:0] REG_UID_LO      = 8'h14;
  localparam logic [7:0] REG_COL         = 8'h18;
  localparam logic [1:0] OP_GET_FEAT     = 2'd0;
  localparam logic [1:0] OP_SET_FEAT     = 2'd1;
  localparam logic [1:0] OP_UID_READ     = 2'd2;
  localparam int         CTRL_GO_BIT     = 0;
  localparam int         CTRL_OP_LSB     = 1;
  localparam int         CTRL_USE_POLL   = 3;
  // Pin timing, in ns, and derived cycles at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_STROBE_NS   = 50;
  localparam int T_ADL_NS      = 200;
  localparam int T_WB_NS       = 100;
  localparam int STROBE_CYC    = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADL_CYC       = (T_ADL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WB_CYC        = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    CYC_IDLE = 3'b000, CYC_SETUP = 3'b001, CYC_LOW = 3'b011, CYC_HIGH = 3'b010
  } cyc_state_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_CMD = 4'b0001, S_ADDR = 4'b0011, S_ADL = 4'b0010,
    S_PWR = 4'b0110, S_BUSY = 4'b0111, S_POLL = 4'b0101, S_RDMODE = 4'b0100,
    S_DOUT = 4'b1100, S_RCOL = 4'b1101, S_DONE = 4'b1111
  } seq_state_t;
endpackage

/* File: nand_pin_cycle.sv */
`timescale 1ns/1ps
module nand_pin_cycle
  import nand_feat_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_ce,
  input  wire logic       i_start,
  input  wire logic [1:0] i_kind,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] i_dq_sync,
  output logic            o_done,
  output logic [7:0]      o_rdata,
  output logic            o_cle,
  output logic            o_ale,
  output logic            o_we_n,
  output logic            o_re_n,
  output logic [7:0]      o_dq,
  output logic            o_dq_oe_n
);
  // Kind: 0 command, 1 address, 2 data write, 3 data read
  cyc_state_t  st_reg, st_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [1:0]  kind_reg, kind_next;
  logic [7:0]  rd_reg, rd_next;
  logic        done_next;
  logic        cle_next, ale_next, we_next, re_next, oe_next;
  logic [7:0]  dq_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    kind_next = kind_reg;
    rd_next = rd_reg;
    done_next = 1'b0;
    cle_next = o_cle;
    ale_next = o_ale;
    we_next = o_we_n;
    re_next = o_re_n;
    oe_next = o_dq_oe_n;
    dq_next = o_dq;
    unique case (st_reg)
      CYC_IDLE: if (i_start) begin
        kind_next = i_kind;
        cle_next = (i_kind == 2'd0);
        ale_next = (i_kind == 2'd1);
        oe_next = (i_kind == 2'd3);
        dq_next = i_wdata;
        cnt_next = 4'(STROBE_CYC);
        st_next = CYC_SETUP;
      end
      CYC_SETUP: begin
        we_next = (kind_reg == 2'd3);
        re_next = (kind_reg != 2'd3);
        st_next = CYC_LOW;
      end
      CYC_LOW: if (cnt_reg == 4'h0) begin
        // Data sampled before RE# rises; the bus is double synchronised
        rd_next = i_dq_sync;
        we_next = 1'b1;
        re_next = 1'b1;
        cnt_next = 4'(STROBE_CYC);
        st_next = CYC_HIGH;
      end else begin
        cnt_next = cnt_reg - 4'h1;
      end
      CYC_HIGH: if (cnt_reg == 4'h0) begin
        cle_next = 1'b0;
        ale_next = 1'b0;
        oe_next = 1'b1;
        done_next = 1'b1;
        st_next = CYC_IDLE;
      end else begin
        cnt_next = cnt_reg - 4'h1;
      end
      default: st_next = CYC_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg <= CYC_IDLE;
      cnt_reg <= 4'h0;
      kind_reg <= 2'd0;
      rd_reg <= 8'h00;
      o_done <= 1'b0;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_we_n <= 1'b1;
      o_re_n <= 1'b1;
      o_dq <= 8'h00;
      o_dq_oe_n <= 1'b1;
    end else if (i_ce) begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      kind_reg <= kind_next;
      rd_reg <= rd_next;
      o_done <= done_next;
      o_cle <= cle_next;
      o_ale <= ale_next;
      o_we_n <= we_next;
      o_re_n <= re_next;
      o_dq <= dq_next;
      o_dq_oe_n <= oe_next;
    end
  end
  assign o_rdata = rd_reg;

  chk_strobe_one_way: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !(o_we_n == 1'b0 && o_re_n == 1'b0))
    else $error("WE# and RE# low together");
  chk_read_released: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    !o_re_n |-> o_dq_oe_n)
    else $error("Data driven while reading");
endmodule
